// [logic/lbm_defs.vh]
// Constants for the segment LCD bias, multiplex and pixel store block
`ifndef LBM_DEFS_VH
`define LBM_DEFS_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define LBM_ADDR_W        6
`define LBM_OFS_CTRL      6'h00
`define LBM_OFS_REF       6'h01
`define LBM_OFS_LADDER    6'h02
`define LBM_OFS_SEGEN0    6'h03
`define LBM_OFS_DIR0      6'h09
`define LBM_OFS_STATUS    6'h0f
`define LBM_OFS_PIX0      6'h10
// ****************************************
// Sizes
// ****************************************
`define LBM_SEG_BYTES     6
`define LBM_SEGS          48
`define LBM_PIX_BYTES     24
`define LBM_COMS          4
// ****************************************
// Control fields
// ****************************************
`define LBM_CTRL_MUX_LSB  0
`define LBM_CTRL_CSEL_LSB 2
`define LBM_CTRL_EN_BIT   7
`define LBM_REF_SRC_LSB   0
`define LBM_REF_IDLE_BIT  2
`define LBM_REF_PIN_LSB   4
`define LBM_LAD_TA_LSB    0
`define LBM_LAD_LP_LSB    4
`define LBM_CST_LSB       0
`define LBM_OFS_CST       6'h0e
// ****************************************
// Encodings and timing
// ****************************************
`define LBM_SRC_NONE      2'h0
`define LBM_SRC_IO        2'h1
`define LBM_SRC_FVR       2'h2
`define LBM_CLK_SYS256    2'h0
`define LBM_CLK_SEC       2'h1
`define LBM_CLK_LFO       2'h2
`define LBM_SYS_DIV       9'h100
`define LBM_BASE_DIV      6'h20
`define LBM_RESET_BYTE    8'h00
`endif

// [logic/lbm_core.v]
// Segment LCD bias, multiplex, pin and pixel store block
`timescale 1ns/100ps
`include "lbm_defs.vh"

// ****************************************
// Register map
// ****************************************
// 00 control: bit 7 module active, bits 3:2 timing
//    clock select, bits 1:0 common count.
// 01 reference: bits 1:0 source, bit 2 buffer idle
//    gate, bits 6:4 bias pin enables.
// 02 ladder: bits 2:0 mode A ticks, bits 7:4 prescale.
// 03-08 segment enables, one bit for each segment pin.
// 09-0d pin direction bytes for segments 0-39.
// 0e contrast step in bits 2:0, common pin direction
//    in bits 7:4; it takes the slot of a sixth
//    direction byte, so segments 40-47 keep their
//    direction at all ones and stay inputs unless enabled as segments.
// 0f status: mode B, buffer on, common index.
// 10-27 pixel store bytes 0-23.
// Reads of unmapped slots return zero; writes to
// them are dropped without side effect.
// Read data stands one cycle after the strobe and
// falls back to zero in every other cycle.
// Bits with no function read back as zero, except control bits 6:4, which read back as written.

// ****************************************
// Hazards for the user
// ****************************************
// Prescale code 0 counts as 1, so the slowest
// frame is reached with code 15.
// Clock select 3 is unused and stops the base tick;
// the frame counter then holds where it is.
// Oscillator ticks are taken as one-cycle enables
// already aligned to the block clock.
// Pixel bytes are read live by the output stage, so
// a write mid-frame shows one cycle later if its common is being driven.
// Clearing the active bit resets the frame counters
// and drops the ladder, reference and common drive at
// once; the bias pin enables stay as written.
// Pixel bytes past the active commons are plain
// storage and never reach the glass.
module lbm_core (
  // Clock and reset
  input  wire                      ref_clk,
  input  wire                      resetn,
  // Register port
  input  wire [`LBM_ADDR_W-1:0]    addr,
  input  wire [7:0]                wdata,
  input  wire                      wr,
  input  wire                      rd,
  output reg  [7:0]                rdata,
  // Timing clock sources, sampled as enables
  input  wire                      sec_osc_tick,
  input  wire                      lfo_tick,
  // Analog control outputs
  output reg  [6:0]                ladder_tap,
  output reg                       ladder_on,
  output reg                       ref_from_io,
  output reg                       ref_from_fvr,
  output reg                       fvr_request,
  output reg                       fvr_buffer_on,
  output reg  [2:0]                bias_pin_en,
  output reg                       ladder_mode_b,
  // Pin ownership
  output reg  [3:0]                common_active,
  output reg  [3:0]                common_dir,
  output reg  [`LBM_SEGS-1:0]      seg_active,
  output reg  [`LBM_SEGS-1:0]      seg_dir,
  // Frame timing
  output reg  [1:0]                common_index,
  output reg                       frame_strobe,
  output reg  [`LBM_SEGS-1:0]      seg_data
);
  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0] ctrl;
  reg  [7:0] refc;
  reg  [7:0] lad;
  reg  [2:0] contrast_step_select;
  reg  [7:0] segen    [0:`LBM_SEG_BYTES-1];
  reg  [7:0] pindir   [0:`LBM_SEG_BYTES-1];
  reg  [7:0] pixel_store [0:`LBM_PIX_BYTES-1];
  reg  [3:0] com_dir_reg;
  reg  [7:0] sys_div;
  reg  [4:0] base_cnt;
  reg  [3:0] pre_cnt;
  reg  [1:0] k_cnt;
  reg        base_tick;
  wire       module_active_flag  = ctrl[`LBM_CTRL_EN_BIT];
  wire [1:0] common_count_select = ctrl[`LBM_CTRL_MUX_LSB +: 2];
  wire [1:0] clk_sel             = ctrl[`LBM_CTRL_CSEL_LSB +: 2];
  wire [1:0] reference_control   = refc[`LBM_REF_SRC_LSB +: 2];
  wire       ref_buffer_idle_gate = refc[`LBM_REF_IDLE_BIT];
  wire [2:0] a_time              = lad[`LBM_LAD_TA_LSB +: 3];
  wire [3:0] frame_prescale      = lad[`LBM_LAD_LP_LSB +: 4];
  integer    i;

  // ****************************************
  // Register writes
  // ****************************************
  // Control, reference and store updates
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl                 <= `LBM_RESET_BYTE;
      refc                 <= `LBM_RESET_BYTE;
      lad                  <= `LBM_RESET_BYTE;
      contrast_step_select <= 3'h0;
      com_dir_reg          <= 4'hf;
      for (i = 0; i < `LBM_SEG_BYTES; i = i + 1) begin
        segen[i]  <= `LBM_RESET_BYTE;
        pindir[i] <= 8'hff;
      end
      for (i = 0; i < `LBM_PIX_BYTES; i = i + 1) begin
        pixel_store[i] <= `LBM_RESET_BYTE;
      end
    end else if (wr) begin
      if (addr == `LBM_OFS_CTRL) begin
        ctrl <= wdata;
      end
      if (addr == `LBM_OFS_REF) begin
        refc <= wdata;
      end
      if (addr == `LBM_OFS_LADDER) begin
        lad <= wdata;
      end
      if (addr == `LBM_OFS_CST) begin
        contrast_step_select <= wdata[2:0];
        com_dir_reg          <= wdata[7:4];
      end
      for (i = 0; i < `LBM_SEG_BYTES; i = i + 1) begin
        if (addr == `LBM_OFS_SEGEN0 + i[5:0]) begin
          segen[i] <= wdata;
        end
        // Sixth direction slot belongs to the contrast byte
        if ((i < `LBM_SEG_BYTES - 1) && (addr == `LBM_OFS_DIR0 + i[5:0])) begin
          pindir[i] <= wdata;
        end
      end
      for (i = 0; i < `LBM_PIX_BYTES; i = i + 1) begin
        if (addr == `LBM_OFS_PIX0 + i[5:0]) begin
          pixel_store[i] <= wdata;
        end
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read data in the cycle after the strobe
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= 8'h00;
      if (addr == `LBM_OFS_CTRL) begin
        rdata <= ctrl;
      end
      if (addr == `LBM_OFS_REF) begin
        rdata <= {1'b0, refc[6:4], 1'b0, refc[2:0]};
      end
      if (addr == `LBM_OFS_LADDER) begin
        rdata <= {lad[7:4], 1'b0, lad[2:0]};
      end
      if (addr == `LBM_OFS_CST) begin
        rdata <= {com_dir_reg, 1'b0, contrast_step_select};
      end
      if (addr == `LBM_OFS_STATUS) begin
        rdata <= {ladder_mode_b, fvr_buffer_on, common_index, 4'h0};
      end
      for (i = 0; i < `LBM_SEG_BYTES; i = i + 1) begin
        if (addr == `LBM_OFS_SEGEN0 + i[5:0]) begin
          rdata <= segen[i];
        end
        if ((i < `LBM_SEG_BYTES - 1) && (addr == `LBM_OFS_DIR0 + i[5:0])) begin
          rdata <= pindir[i];
        end
      end
      for (i = 0; i < `LBM_PIX_BYTES; i = i + 1) begin
        if (addr == `LBM_OFS_PIX0 + i[5:0]) begin
          rdata <= pixel_store[i];
        end
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // ****************************************
  // Frame timing overview
  // ****************************************
  // One base tick comes from the selected source.
  // Thirty-two base ticks make one prescale step.
  // Prescale steps repeat frame_prescale times, once for code 0.
  // Static drive repeats that four times, half
  // multiplex twice, third and quarter once.
  // Each completed k count moves to the next common.
  // After the last active common the index wraps and
  // frame_strobe pulses for a single cycle.
  // Mode A covers the first a_time base ticks after
  // each common change, plus one tick after the 32nd
  // when the common runs longer; the rest is mode B.
  // With a_time at zero the ladder never leaves B.
  // All frame counters clear while the module is inactive,
  // so a restart always begins at common zero.
  // The base tick is registered, which delays every
  // boundary by one clock; periods are unaffected.

  // ****************************************
  // Timing clock and prescaler
  // ****************************************
  // Source select gives a base tick
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sys_div   <= 8'h00;
      base_tick <= 1'b0;
    end else begin
      sys_div <= sys_div + 8'h01;
      case (clk_sel)
        `LBM_CLK_SYS256: base_tick <= (sys_div == 8'hff);
        `LBM_CLK_SEC:    base_tick <= sec_osc_tick;
        `LBM_CLK_LFO:    base_tick <= lfo_tick;
        default:         base_tick <= 1'b0;
      endcase
    end
  end

  // Divide by 32, prescale, k, commons
  wire [1:0] k_max = (common_count_select == 2'h0) ? 2'h3 :
                     (common_count_select == 2'h1) ? 2'h1 : 2'h0;
  wire [3:0] pre_max = (frame_prescale == 4'h0) ? 4'h0 : frame_prescale - 4'h1;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      base_cnt      <= 5'h00;
      pre_cnt       <= 4'h0;
      k_cnt         <= 2'h0;
      common_index  <= 2'h0;
      frame_strobe  <= 1'b0;
      ladder_mode_b <= 1'b1;
    end else if (!module_active_flag) begin
      base_cnt      <= 5'h00;
      pre_cnt       <= 4'h0;
      k_cnt         <= 2'h0;
      common_index  <= 2'h0;
      frame_strobe  <= 1'b0;
      ladder_mode_b <= 1'b1;
    end else begin
      frame_strobe <= 1'b0;
      if (base_tick) begin
        base_cnt <= base_cnt + 5'h01;
        // Mode A from output change for a_time ticks, then B; the first mid-common base_cnt wrap gives one more A tick
        ladder_mode_b <= ({2'h0, a_time} <= base_cnt + 5'h01) || (pre_cnt != 4'h0) || (k_cnt != 2'h0);
        if (base_cnt == 5'h1f) begin
          if (pre_cnt >= pre_max) begin
            pre_cnt <= 4'h0;
            if (k_cnt >= k_max) begin
              k_cnt <= 2'h0;
              ladder_mode_b <= (a_time == 3'h0);
              if (common_index >= common_count_select) begin
                common_index <= 2'h0;
                frame_strobe <= 1'b1;
              end else begin
                common_index <= common_index + 2'h1;
              end
            end else begin
              k_cnt <= k_cnt + 2'h1;
            end
          end else begin
            pre_cnt <= pre_cnt + 4'h1;
          end
        end
      end
    end
  end

  // ****************************************
  // Pin and bias overview
  // ****************************************
  // Segment pins driven by the block report direction
  // zero; others pass their direction bit through.
  // Commons beyond the count field act as plain pins
  // and follow their own direction bits.
  // Ladder taps form a thermometer: code s sets the
  // low s taps, code 0 sets none.
  // The ladder and internal reference run only while
  // the module is active and the source field is not
  // zero; code 3 runs the ladder with no source chosen.
  // The fixed reference is requested whenever it is
  // the chosen source and the module is active; no software enable is needed.
  // Its buffer rests in mode B only when the idle
  // gate is set, to save current between edges.
  // Bias pin enables pass straight through and leave
  // the internal ladder running beside them.

  // ****************************************
  // Bias, contrast and pin control
  // ****************************************
  // Outputs registered from configuration
  genvar g;
  generate
    for (g = 0; g < `LBM_SEGS; g = g + 1) begin : g_seg
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          seg_active[g] <= 1'b0;
          seg_dir[g]    <= 1'b1;
          seg_data[g]   <= 1'b0;
        end else begin
          seg_active[g] <= segen[g/8][g%8];
          seg_dir[g]    <= segen[g/8][g%8] ? 1'b0 : pindir[g/8][g%8];
          seg_data[g]   <= pixel_store[(g/24)*12 + common_index*3 + (g%24)/8][g%8];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ladder_tap    <= 7'h00;
      ladder_on     <= 1'b0;
      ref_from_io   <= 1'b0;
      ref_from_fvr  <= 1'b0;
      fvr_request   <= 1'b0;
      fvr_buffer_on <= 1'b0;
      bias_pin_en   <= 3'h0;
      common_active <= 4'h0;
      common_dir    <= 4'hf;
    end else begin
      // Thermometer tap, 000 no drop
      ladder_tap   <= (7'h7f >> (3'h7 - contrast_step_select)) & 7'h7f ^ 7'h00;
      ladder_on    <= module_active_flag && (reference_control != `LBM_SRC_NONE);
      ref_from_io  <= module_active_flag && (reference_control == `LBM_SRC_IO);
      ref_from_fvr <= module_active_flag && (reference_control == `LBM_SRC_FVR);
      fvr_request  <= module_active_flag && (reference_control == `LBM_SRC_FVR);
      fvr_buffer_on <= module_active_flag && (reference_control == `LBM_SRC_FVR) &&
                       !(ref_buffer_idle_gate && ladder_mode_b);
      bias_pin_en  <= refc[`LBM_REF_PIN_LSB +: 3];
      for (i = 0; i < `LBM_COMS; i = i + 1) begin
        common_active[i] <= module_active_flag && (i[1:0] <= common_count_select);
        common_dir[i]    <= (module_active_flag && (i[1:0] <= common_count_select)) ?
                            1'b0 : com_dir_reg[i];
      end
    end
  end
endmodule // lbm_core

// [dv/lbm_monitor.sv]
// Port checker for the LCD bias, pin and frame block
`timescale 1ns/100ps
`include "lbm_defs.vh"
module lbm_monitor (
  // Clock, reset and bus
  input wire                  ref_clk,
  input wire                  resetn,
  input wire                  rd,
  input wire [7:0]            rdata,
  // Bias controls
  input wire [6:0]            ladder_tap,
  input wire                  ladder_on,
  input wire                  ref_from_io,
  input wire                  ref_from_fvr,
  input wire                  fvr_request,
  input wire                  fvr_buffer_on,
  // Pins and frame
  input wire [3:0]            common_active,
  input wire [3:0]            common_dir,
  input wire [`LBM_SEGS-1:0]  seg_active,
  input wire [`LBM_SEGS-1:0]  seg_dir,
  input wire                  frame_strobe
);
  // ****************************************
  // Relations between outputs
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_ladder_src; ladder_on |-> (ref_from_io || ref_from_fvr); endproperty
  a_ladder_src: assert property (p_ladder_src) else $error("ladder on without source");
  property p_one_src; !(ref_from_io && ref_from_fvr); endproperty
  a_one_src: assert property (p_one_src) else $error("two reference sources");
  property p_fvr_req; (ref_from_fvr || fvr_buffer_on) |-> fvr_request; endproperty
  a_fvr_req: assert property (p_fvr_req) else $error("fixed reference not requested");
  property p_tap; (ladder_tap & (ladder_tap + 7'h01)) == 7'h00; endproperty
  a_tap: assert property (p_tap) else $error("ladder tap not monotonic");
  property p_com; common_active inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf} && (common_active & common_dir) == 4'h0; endproperty
  a_com: assert property (p_com) else $error("common usage wrong");
  property p_seg; (seg_active & seg_dir) == {`LBM_SEGS{1'b0}}; endproperty
  a_seg: assert property (p_seg) else $error("segment direction not overridden");
  property p_strobe; frame_strobe |=> !frame_strobe [*8]; endproperty
  a_strobe: assert property (p_strobe) else $error("frame strobe too close");
endmodule // lbm_monitor
bind lbm_core lbm_monitor u_mon (.ref_clk, .resetn, .rd, .rdata, .ladder_tap, .ladder_on, .ref_from_io,
  .ref_from_fvr, .fvr_request, .fvr_buffer_on, .common_active, .common_dir, .seg_active, .seg_dir, .frame_strobe);

// [dv/lbm_panel.sv]
// Passive segment glass that records the pixels driven per common
`timescale 1ns/100ps
`include "lbm_defs.vh"
module lbm_panel (
  // Clock and reset
  input wire                  ref_clk,
  input wire                  resetn,
  // Drive from the block
  input wire [3:0]            common_active,
  input wire [1:0]            common_index,
  input wire [`LBM_SEGS-1:0]  seg_data
);
  reg [`LBM_SEGS-1:0] view [0:3];
  // Latch the pattern of the common being driven
  always @(posedge ref_clk) begin
    if (resetn && common_active[common_index]) view[common_index] <= seg_data;
  end
endmodule // lbm_panel

// [dv/testbench.sv]
// Self-checking bench for the LCD bias, pin and pixel block
`timescale 1ns/100ps
`include "lbm_defs.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  reg                  ref_clk, resetn, wr, rd, sec_osc_tick, lfo_tick;
  reg [5:0]            addr;
  reg [7:0]            wdata, d;
  reg [6:0]            e7;
  wire [7:0]           rdata;
  wire [6:0]           ladder_tap;
  wire                 ladder_on, ref_from_io, ref_from_fvr, fvr_request, fvr_buffer_on, ladder_mode_b, frame_strobe;
  wire [2:0]           bias_pin_en;
  wire [3:0]           common_active, common_dir;
  wire [1:0]           common_index;
  wire [`LBM_SEGS-1:0] seg_active, seg_dir, seg_data;
  integer              n_mismatch = 0, num_checks = 0, i, n, cyc;
  lbm_core dut (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .sec_osc_tick, .lfo_tick, .ladder_tap, .ladder_on,
    .ref_from_io, .ref_from_fvr, .fvr_request, .fvr_buffer_on, .bias_pin_en, .ladder_mode_b, .common_active,
    .common_dir, .seg_active, .seg_dir, .common_index, .frame_strobe, .seg_data);
  lbm_panel panel (.ref_clk, .resetn, .common_active, .common_index, .seg_data);
  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Oscillator ticks: secondary every 2, low-frequency every 3 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    sec_osc_tick <= (cyc % 2 == 0);
    lfo_tick <= (cyc % 3 == 0);
  end
  // ****************************************
  // Bus and wait tasks
  // ****************************************
  task wrr(input [5:0] a, input [7:0] v);
    begin
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
    end
  endtask
  task rdr(input [5:0] a);
    begin
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task wait_strobe;
    begin
      n = 0;
      while (frame_strobe !== 1'b1 && n < 70000) begin
        @(posedge ref_clk);
        #1 n = n + 1;
      end
      if (n == 70000) begin
        n_mismatch++;
        final_report;
      end
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    begin
      `CHK(seg_active, {`LBM_SEGS{1'b0}})
      rdr(`LBM_OFS_SEGEN0);
      `CHK(d, 8'h00)
      rdr(`LBM_OFS_DIR0);
      `CHK(d, 8'hff)
    end
  endtask
  task t_bias;
    begin
      wrr(`LBM_OFS_CTRL, 8'h80);
      wrr(`LBM_OFS_REF, 8'h51);
      `CHK({ref_from_io, ref_from_fvr, ladder_on, bias_pin_en}, 6'h2d)
      wrr(`LBM_OFS_REF, 8'h02);
      `CHK({ref_from_io, ref_from_fvr, fvr_request, ladder_on}, 4'h7)
      wrr(`LBM_OFS_REF, 8'h00);
      `CHK({ref_from_io, ref_from_fvr, ladder_on}, 3'h0)
      wrr(`LBM_OFS_REF, 8'h06);
      `CHK({ladder_mode_b, fvr_buffer_on}, 2'h2)
      rdr(`LBM_OFS_STATUS);
      `CHK(d[7], 1'b1)
      wrr(`LBM_OFS_REF, 8'h02);
      `CHK(fvr_buffer_on, 1'b1)
      wrr(`LBM_OFS_CTRL, 8'h00);
      `CHK({ref_from_io, ref_from_fvr, ladder_on}, 3'h0)
    end
  endtask
  task t_tap_mux;
    begin
      wrr(`LBM_OFS_CTRL, 8'h80);
      for (i = 0; i < 8; i = i + 1) begin
        wrr(`LBM_OFS_CST, 8'hf0 | i);
        e7 = ~(7'h7f << i);
        `CHK(ladder_tap, e7)
      end
      for (i = 0; i < 4; i = i + 1) begin
        wrr(`LBM_OFS_CTRL, 8'h80 | i);
        `CHK({common_active, common_dir}, {~(4'hf << (i + 1)), 4'hf << (i + 1)})
      end
      wrr(`LBM_OFS_CTRL, 8'h80);
      wrr(`LBM_OFS_CST, 8'h57);
      `CHK(common_dir, 4'h4)
      wrr(`LBM_OFS_SEGEN0, 8'ha5);
      wrr(`LBM_OFS_DIR0, 8'h0f);
      `CHK({seg_active[7:0], seg_dir[7:0]}, 16'ha50a)
    end
  endtask
  task run_frame(input [7:0] ctl, input [7:0] lad, input integer exp);
    begin
      wrr(`LBM_OFS_LADDER, lad);
      wrr(`LBM_OFS_CTRL, ctl);
      wait_strobe;
      @(posedge ref_clk);
      #1 wait_strobe;
      `CHK(n + 1, exp)
    end
  endtask
  task t_pixels;
    begin
      for (i = 0; i < `LBM_PIX_BYTES; i = i + 1) wrr(`LBM_OFS_PIX0 + i, {i[4:0], 3'h5});
      for (i = 0; i < `LBM_PIX_BYTES; i = i + 1) begin
        rdr(`LBM_OFS_PIX0 + i);
        `CHK(d, {i[4:0], 3'h5})
      end
      wrr(6'h3f, 8'hff);
      rdr(6'h3f);
      `CHK(d, 8'h00)
      run_frame(8'h87, 8'h20, 512);
      for (i = 0; i < 4; i = i + 1) begin
        `CHK({panel.view[i][31:24], panel.view[i][7:0]}, {5'(12 + 3 * i), 3'h5, 5'(3 * i), 3'h5})
      end
      run_frame(8'h88, 8'h10, 384);
      run_frame(8'h81, 8'h00, 32768);
    end
  endtask
  // Reset, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 6'h00;
    wdata = 8'h00;
    cyc = 0;
    sec_osc_tick = 1'b0;
    lfo_tick = 1'b0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset;
    t_bias;
    t_tap_mux;
    t_pixels;
    final_report;
  end
endmodule // testbench
